// ---- rtl/programmable_interval_timer.sv ----
// Three-channel interval timer with its byte-wide host port.
`timescale 1ns/100ps
module programmable_interval_timer
  import pit_pkg::*;
#(
  parameter int NUM_CH = 3,
  parameter int DIV = INT_DIV
)
(
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire io_req_s io_req_i,
  input wire logic external_timer_clock_i,
  input wire logic [1:0] channel01_gate_i,
  input wire logic channel2_gate_i,
  input wire logic [2:0] timer_clock_select_cfg_i,
  input wire logic [1:0] prescale_field_i,
  input wire logic peripheral_routing_cfg_i,
  output logic [7:0] rdata_o,
  output logic irq0_o,
  output logic irq2_o,
  output logic baud_clk_o,
  output logic channel2_output_o
);

  // BCD or binary decrement by one, wrapping to the top of the range.
  function automatic logic [15:0] dec_one(input logic [15:0] v, input logic bcd);
    logic [15:0] r;
    logic borrow;
    r = v;
    borrow = 1'b1;
    if (!bcd)
    begin
      r = v - CNT_ONE;
    end
    else
    begin
      for (int i = 0; i < 4; i++)
      begin
        if (borrow)
        begin
          if (r[4*i +: 4] == 4'h0)
          begin
            r[4*i +: 4] = 4'h9;
          end
          else
          begin
            r[4*i +: 4] = r[4*i +: 4] - 4'h1;
            borrow = 1'b0;
          end
        end
      end
    end
    return r;
  endfunction

  logic [NUM_CH-1:0] tick;
  logic [NUM_CH-1:0] gate_s1_q;
  logic [NUM_CH-1:0] gate_s2_q;
  logic [NUM_CH-1:0] gate_s3_q;
  logic [NUM_CH-1:0] out_q;
  logic [7:0] rd_byte [NUM_CH];
  logic [7:0] rdata_q;
  logic irq2_q;
  wire cw_wr;
  wire [1:0] cw_sel;
  wire [7:0] rdata_d;

  // Clock enables for each channel.
  timer_tick_gen #(
    .NUM_CH(NUM_CH),
    .DIV(DIV)
  ) u_tick (
    .sys_clk_i(sys_clk_i),
    .rst_i(rst_i),
    .ext_clk_i(external_timer_clock_i),
    .clk_sel_i(timer_clock_select_cfg_i),
    .prescale_i(prescale_field_i),
    .tick_o(tick)
  );

  // Gate pins pass two flops; they reset high, the open level, so no false rising edge follows reset.
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      gate_s1_q <= '1;
      gate_s2_q <= '1;
      gate_s3_q <= '1;
    end
    else
    begin
      gate_s1_q <= {channel2_gate_i, channel01_gate_i};
      gate_s2_q <= gate_s1_q;
      gate_s3_q <= gate_s2_q;
    end
  end

  // Control word decode shared by all channels.
  assign cw_wr = io_req_i.wr && (io_req_i.addr == OFS_CTRL);
  assign cw_sel = io_req_i.data[CW_SEL_LO +: 2];

  for (genvar g = 0; g < NUM_CH; g++)
  begin : g_ch
    chan_cfg_s cfg_q;
    logic [15:0] cnt_q;
    logic [15:0] ld_q;
    logic [15:0] cl_q;
    logic [7:0] sl_q;
    logic null_q;
    logic new_q;
    logic have_q;
    logic ldok_q;
    logic wflip_q;
    logic rflip_q;
    logic cl_vld_q;
    logic sl_vld_q;
    logic gtrig_q;
    logic [15:0] cnt_d;
    logic [15:0] ld_d;
    logic out_d;
    logic have_d;
    logic loaded;
    logic trig_use;
    logic [15:0] rd_src;
    wire [2:0] m;
    wire m23;
    wire m04;
    wire m15;
    wire sel_me;
    wire wr_cnt;
    wire rd_cnt;
    wire cw_me;
    wire cw_mode;
    wire cw_clatch;
    wire ml_me;
    wire do_clatch;
    wire do_slatch;
    wire wr_done;
    wire g_lvl;
    wire g_rise;
    wire load_now;
    wire cnt_en;
    wire [7:0] st_byte;

    // Port and command decode for this channel.
    assign sel_me = (io_req_i.addr == 2'(g));
    assign wr_cnt = io_req_i.wr && sel_me;
    assign rd_cnt = io_req_i.rd && sel_me;
    assign cw_me = cw_wr && (cw_sel == 2'(g));
    assign cw_mode = cw_me && (io_req_i.data[CW_RW_LO +: 2] != RW_LATCH);
    assign cw_clatch = cw_me && (io_req_i.data[CW_RW_LO +: 2] == RW_LATCH);
    assign ml_me = cw_wr && (cw_sel == SEL_MULTI) && io_req_i.data[ML_CH0 + g];
    assign do_clatch = ((cw_clatch || (ml_me && !io_req_i.data[ML_COUNT_N])) && !cl_vld_q);
    assign do_slatch = ml_me && !io_req_i.data[ML_STATUS_N] && !sl_vld_q;
    assign wr_done = wr_cnt && ((cfg_q.rw != RW_BOTH) || wflip_q);

    // Mode folding and gate handling.
    assign m = cfg_q.mode[1] ? {1'b0, cfg_q.mode[1:0]} : cfg_q.mode;
    assign m23 = (m == MODE_RATE) || (m == MODE_SQUARE);
    assign m04 = (m == MODE_INT_TC) || (m == MODE_SW_STROBE);
    assign m15 = (m == MODE_ONESHOT) || (m == MODE_HW_STROBE);
    assign g_lvl = gate_s2_q[g];
    assign g_rise = gate_s2_q[g] & ~gate_s3_q[g];
    assign load_now = (new_q && (m04 || (m23 && !have_q))) || (gtrig_q && ldok_q && !m04);
    assign cnt_en = m15 || (g_lvl && !((m == MODE_INT_TC) && wflip_q));
    assign st_byte = {out_q[g], null_q, cfg_q};

    // Assembly of the count register from host bytes.
    always_comb
    begin
      ld_d = ld_q;
      unique case (cfg_q.rw)
        RW_LOW: ld_d = {8'h00, io_req_i.data};
        RW_HIGH: ld_d = {io_req_i.data, 8'h00};
        RW_BOTH: ld_d = wflip_q ? {io_req_i.data, ld_q[7:0]} : {ld_q[15:8], io_req_i.data};
        RW_LATCH: ld_d = ld_q;
      endcase
    end

    // Counting, reload and output waveform on each count clock.
    always_comb
    begin
      cnt_d = cnt_q;
      out_d = out_q[g];
      have_d = have_q;
      loaded = 1'b0;
      trig_use = 1'b0;
      if (tick[g])
      begin
        if (load_now)
        begin
          cnt_d = ld_q;
          loaded = 1'b1;
          have_d = 1'b1;
          trig_use = gtrig_q;
          out_d = !((m == MODE_INT_TC) || (m == MODE_ONESHOT));
        end
        else if (have_q && cnt_en)
        begin
          cnt_d = dec_one(cnt_q, cfg_q.bcd);
          case (m)
            MODE_INT_TC, MODE_ONESHOT:
            begin
              if (cnt_q == CNT_ONE)
              begin
                out_d = 1'b1;
              end
            end
            MODE_RATE:
            begin
              if (cnt_q == CNT_TWO)
              begin
                out_d = 1'b0;
              end
              else if (cnt_q == CNT_ONE)
              begin
                out_d = 1'b1;
                cnt_d = ld_q;
                loaded = 1'b1;
              end
            end
            MODE_SQUARE:
            begin
              cnt_d = dec_one(dec_one(cnt_q, cfg_q.bcd), cfg_q.bcd);
              if (cnt_q <= CNT_TWO)
              begin
                out_d = ~out_q[g];
                cnt_d = ld_q;
                loaded = 1'b1;
              end
            end
            default:
            begin
              out_d = (cnt_q != CNT_ONE);
              if (cnt_q == CNT_RST)
              begin
                have_d = 1'b0;
              end
            end
          endcase
        end
      end
      if (m23 && !g_lvl)
      begin
        out_d = 1'b1;
      end
    end

    // Channel configuration, count register and down counter.
    always_ff @(posedge sys_clk_i)
    begin
      if (rst_i)
      begin
        cfg_q <= CFG_RST;
        cnt_q <= CNT_RST;
        ld_q <= CNT_RST;
        out_q[g] <= 1'b0;
        null_q <= 1'b1;
        new_q <= 1'b0;
        have_q <= 1'b0;
        ldok_q <= 1'b0;
        wflip_q <= 1'b0;
        gtrig_q <= 1'b0;
      end
      else if (cw_mode)
      begin
        cfg_q <= chan_cfg_s'(io_req_i.data[5:0]);
        out_q[g] <= (io_req_i.data[CW_MODE_LO +: 3] != MODE_INT_TC);
        null_q <= 1'b1;
        new_q <= 1'b0;
        have_q <= 1'b0;
        ldok_q <= 1'b0;
        wflip_q <= 1'b0;
        gtrig_q <= 1'b0;
      end
      else
      begin
        cnt_q <= cnt_d;
        have_q <= have_d;
        out_q[g] <= (wr_cnt && (m == MODE_INT_TC)) ? 1'b0 : out_d;
        if (wr_cnt)
        begin
          ld_q <= ld_d;
          wflip_q <= (cfg_q.rw == RW_BOTH) && !wflip_q;
        end
        new_q <= wr_done || (new_q && !loaded);
        null_q <= wr_done || (null_q && !loaded);
        ldok_q <= ldok_q || wr_done;
        gtrig_q <= g_rise || (gtrig_q && !trig_use);
      end
    end

    // Latched count and status, consumed by host reads in order.
    always_ff @(posedge sys_clk_i)
    begin
      if (rst_i)
      begin
        cl_q <= CNT_RST;
        sl_q <= 8'h00;
        cl_vld_q <= 1'b0;
        sl_vld_q <= 1'b0;
        rflip_q <= 1'b0;
      end
      else if (cw_mode)
      begin
        cl_vld_q <= 1'b0;
        sl_vld_q <= 1'b0;
        rflip_q <= 1'b0;
      end
      else
      begin
        if (do_clatch)
        begin
          cl_q <= cnt_q;
          cl_vld_q <= 1'b1;
        end
        if (do_slatch)
        begin
          sl_q <= st_byte;
          sl_vld_q <= 1'b1;
        end
        if (rd_cnt && sl_vld_q)
        begin
          sl_vld_q <= 1'b0;
        end
        else if (rd_cnt && (cfg_q.rw == RW_BOTH) && !rflip_q)
        begin
          rflip_q <= 1'b1;
        end
        else if (rd_cnt)
        begin
          rflip_q <= 1'b0;
          cl_vld_q <= 1'b0;
        end
      end
    end

    // Read byte: latched status first, then latched or live count.
    always_comb
    begin
      rd_src = cl_vld_q ? cl_q : cnt_q;
      if (sl_vld_q)
      begin
        rd_byte[g] = sl_q;
      end
      else if ((cfg_q.rw == RW_HIGH) || ((cfg_q.rw == RW_BOTH) && rflip_q))
      begin
        rd_byte[g] = rd_src[15:8];
      end
      else
      begin
        rd_byte[g] = rd_src[7:0];
      end
    end
  end

  // The control port reads as zero.
  assign rdata_d = (io_req_i.addr == OFS_CTRL) ? 8'h00 : rd_byte[io_req_i.addr];

  // Registered read data and interrupt routing of channel 1.
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      rdata_q <= 8'h00;
      irq2_q <= 1'b0;
    end
    else
    begin
      if (io_req_i.rd)
      begin
        rdata_q <= rdata_d;
      end
      irq2_q <= peripheral_routing_cfg_i && out_q[1];
    end
  end

  // Outputs come straight from flops.
  assign rdata_o = rdata_q;
  assign irq0_o = out_q[0];
  assign baud_clk_o = out_q[1];
  assign irq2_o = irq2_q;
  assign channel2_output_o = out_q[2];

endmodule

// ---- common/pit_pkg.sv ----
// Shared constants, field layouts and types for the programmable interval timer.
// Operation
// - Three independent 16-bit down counters.
// - Binary to FFFFh or BCD to 9999.
// - Per-channel clock: internal 8 MHz or external.
// - Shared prescale divides the internal clock.
// - Channel 0 output drives interrupt request 0.
// - Channel 1 gives baud clock, optionally request 2.
// - Channel 2 output and gate on pins.
// - Offsets 0-2 channel ports, 3 control word.
// - Select field all ones means multiple latch.
// - Access: low, high, both, or count latch.
// - Two-byte transfers go low byte first.
// - New count any time, same byte count.
// - Count latch: low six bits zero, channel select.
// - Multiple latch: channel bits, status/count flags.
// - Status needs latch; live count reads allowed.
// - Status low six bits echo channel configuration.
// - Null flag until written count reaches counter.
// - Status bit shows present output level.
// - Single-byte access: status read, then count byte.
// - Two-byte access: status, then low, high bytes.
// - Six counting modes per channel.
package pit_pkg;

  // Byte offsets of the four ports.
  localparam logic [1:0] OFS_CH0 = 2'h0;
  localparam logic [1:0] OFS_CH1 = 2'h1;
  localparam logic [1:0] OFS_CH2 = 2'h2;
  localparam logic [1:0] OFS_CTRL = 2'h3;

  // Control word field positions.
  localparam int CW_SEL_LO = 6;
  localparam int CW_RW_LO = 4;
  localparam int CW_MODE_LO = 1;
  localparam int CW_BCD = 0;
  localparam int ML_COUNT_N = 5;
  localparam int ML_STATUS_N = 4;
  localparam int ML_CH0 = 1;
  localparam logic [1:0] SEL_MULTI = 2'h3;

  // Status byte positions above the echoed configuration.
  localparam int ST_OUT = 7;
  localparam int ST_NULL = 6;

  // Counting modes after folding codes 6 and 7 onto 2 and 3.
  localparam logic [2:0] MODE_INT_TC = 3'h0;
  localparam logic [2:0] MODE_ONESHOT = 3'h1;
  localparam logic [2:0] MODE_RATE = 3'h2;
  localparam logic [2:0] MODE_SQUARE = 3'h3;
  localparam logic [2:0] MODE_SW_STROBE = 3'h4;
  localparam logic [2:0] MODE_HW_STROBE = 3'h5;

  // Count limits and reset values.
  localparam logic [15:0] CNT_ONE = 16'h0001;
  localparam logic [15:0] CNT_TWO = 16'h0002;
  localparam logic [15:0] CNT_RST = 16'h0000;

  // Clock rates; the internal count clock is derived from the system clock.
  localparam int SYS_CLK_HZ = 125_000_000;
  localparam int INT_CLK_HZ = 8_000_000;
  localparam int INT_DIV = SYS_CLK_HZ / INT_CLK_HZ;
  localparam int PRE_W = 5;

  // Byte access codes.
  typedef enum logic [1:0] {
    RW_LATCH = 2'b00,
    RW_LOW = 2'b01,
    RW_HIGH = 2'b10,
    RW_BOTH = 2'b11
  } rw_e;

  // Per-channel configuration, also the low six status bits.
  typedef struct packed {
    rw_e rw;
    logic [2:0] mode;
    logic bcd;
  } chan_cfg_s;

  localparam chan_cfg_s CFG_RST = '{rw: RW_LOW, mode: 3'h0, bcd: 1'b0};

  // One host I/O cycle on the byte port.
  typedef struct packed {
    logic wr;
    logic rd;
    logic [1:0] addr;
    logic [7:0] data;
  } io_req_s;

endpackage

// ---- rtl/timer_tick_gen.sv ----
// Count clock enables: internal prescaled clock or synchronised external clock.
`timescale 1ns/100ps
module timer_tick_gen
  import pit_pkg::*;
#(
  parameter int NUM_CH = 3,
  parameter int DIV = INT_DIV
)
(
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic ext_clk_i,
  input wire logic [NUM_CH-1:0] clk_sel_i,
  input wire logic [1:0] prescale_i,
  output logic [NUM_CH-1:0] tick_o
);

  logic ext_s1_q;
  logic ext_s2_q;
  logic ext_s3_q;
  logic [7:0] div_q;
  logic [PRE_W-1:0] pre_q;
  logic [NUM_CH-1:0] tick_q;
  wire ext_rise;
  wire int_tick;
  wire pre_tick;
  wire [PRE_W-1:0] pre_lim;

  // External clock passes two flops, the third only feeds the edge detector.
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      ext_s1_q <= 1'b0;
      ext_s2_q <= 1'b0;
      ext_s3_q <= 1'b0;
    end
    else
    begin
      ext_s1_q <= ext_clk_i;
      ext_s2_q <= ext_s1_q;
      ext_s3_q <= ext_s2_q;
    end
  end

  // Rising edge of the external clock, and the internal clock divider terminal.
  assign ext_rise = ext_s2_q & ~ext_s3_q;
  assign int_tick = (div_q == 8'(DIV - 1));
  assign pre_lim = PRE_W'((5'h02 << prescale_i) - 5'h01);
  assign pre_tick = int_tick && (pre_q == pre_lim);

  // Internal clock divider followed by the shared prescaler.
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      div_q <= 8'h00;
      pre_q <= '0;
    end
    else
    begin
      div_q <= int_tick ? 8'h00 : div_q + 8'h01;
      if (int_tick)
      begin
        pre_q <= (pre_q >= pre_lim) ? '0 : pre_q + PRE_W'(1);
      end
    end
  end

  // Per-channel source selection; a one selects the external clock.
  for (genvar g = 0; g < NUM_CH; g++)
  begin : g_sel
    always_ff @(posedge sys_clk_i)
    begin
      if (rst_i)
      begin
        tick_q[g] <= 1'b0;
      end
      else
      begin
        tick_q[g] <= clk_sel_i[g] ? ext_rise : pre_tick;
      end
    end
  end

  assign tick_o = tick_q;

endmodule

// ---- tb/programmable_interval_timer_assertions.sv ----
// Concurrent checks on the interval timer's ports.
`timescale 1ns/100ps
module programmable_interval_timer_assertions
  import pit_pkg::*;
#(
  parameter int NUM_CH = 3,
  parameter int DIV = INT_DIV
)
(
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire io_req_s io_req_i,
  input wire logic peripheral_routing_cfg_i,
  input wire logic [7:0] rdata_o,
  input wire logic irq0_o,
  input wire logic irq2_o,
  input wire logic baud_clk_o,
  input wire logic channel2_output_o
);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);

  // A control word write that gives one channel a counting mode.
  sequence cw_mode(logic [1:0] sel, logic [2:0] md);
    io_req_i.wr && io_req_i.addr == OFS_CTRL && io_req_i.data[7:6] == sel &&
      io_req_i.data[5:4] != RW_LATCH && io_req_i.data[3:1] == md;
  endsequence

  // Mode programming sets each output to its starting level.
  a_ch0_mode0_low: assert property (cw_mode(2'h0, MODE_INT_TC) |=> !irq0_o [*3])
    else $error("channel 0 output not low after mode 0 setup");
  a_ch0_mode2_high: assert property (cw_mode(2'h0, MODE_RATE) |=> irq0_o)
    else $error("channel 0 output not high after mode 2 setup");
  a_ch1_mode0_low: assert property (cw_mode(2'h1, MODE_INT_TC) |=> !baud_clk_o)
    else $error("channel 1 output not low after mode 0 setup");
  a_ch2_mode0_low: assert property (cw_mode(2'h2, MODE_INT_TC) |=> !channel2_output_o [*2])
    else $error("channel 2 output not low after mode 0 setup");

  // Interrupt request 2 follows channel 1 only when routed.
  a_irq2_route_follow: assert property (irq2_o == $past(baud_clk_o && peripheral_routing_cfg_i))
    else $error("irq2 does not follow routed channel 1 output");

  // Read data moves only in answer to a read strobe.
  a_rdata_held: assert property (!$stable(rdata_o) |-> $past(io_req_i.rd) || $past(io_req_i.rd, 2))
    else $error("read data changed without a read");
  a_ctrl_read_zero: assert property (io_req_i.rd && io_req_i.addr == OFS_CTRL |-> ##[1:2] rdata_o == 8'h00)
    else $error("control port read did not return zero");

  // Reset clears every output.
  a_reset_outputs_quiet: assert property (disable iff (1'b0) rst_i |=>
    !irq0_o && !irq2_o && !baud_clk_o && !channel2_output_o && rdata_o == 8'h00)
    else $error("outputs not cleared by reset");
endmodule

bind programmable_interval_timer programmable_interval_timer_assertions #(.NUM_CH(NUM_CH), .DIV(DIV))
  i_programmable_interval_timer_assertions (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .io_req_i(io_req_i),
  .peripheral_routing_cfg_i(peripheral_routing_cfg_i), .rdata_o(rdata_o), .irq0_o(irq0_o),
  .irq2_o(irq2_o), .baud_clk_o(baud_clk_o), .channel2_output_o(channel2_output_o));

// ---- tb/pit_host.sv ----
// Host processor model driving byte-wide I/O cycles.
`timescale 1ns/100ps
module pit_host
  import pit_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic [7:0] rdata_i,
  output io_req_s io_req_o
);
  // The bus starts idle.
  initial io_req_o = '0;

  // One write strobe; the data lines flip once released.
  task automatic write_byte(input logic [1:0] a, input logic [7:0] d);
    @(negedge sys_clk_i);
    io_req_o = '{wr: 1'b1, rd: 1'b0, addr: a, data: d};
    @(negedge sys_clk_i);
    io_req_o = '{wr: 1'b0, rd: 1'b0, addr: a, data: ~d};
  endtask

  // One read strobe; data is taken once the registered answer has settled.
  task automatic read_byte(input logic [1:0] a, output logic [7:0] d);
    @(negedge sys_clk_i);
    io_req_o = '{wr: 1'b0, rd: 1'b1, addr: a, data: ~io_req_o.data};
    @(negedge sys_clk_i);
    io_req_o.rd = 1'b0;
    @(negedge sys_clk_i);
    d = rdata_i;
  endtask

  // A count in the channel's byte format, low byte first when both are due.
  task automatic write_count(input logic [1:0] a, input logic [15:0] v, input rw_e f);
    if (f != RW_HIGH) write_byte(a, v[7:0]);
    if (f == RW_HIGH || f == RW_BOTH) write_byte(a, v[15:8]);
  endtask
endmodule

// ---- tb/programmable_interval_timer_tb.sv ----
// Self-checking bench for the interval timer through its byte port.
`timescale 1ns/100ps
module programmable_interval_timer_tb
  import pit_pkg::*;
;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic ext_clk = 1'b0;
  logic [2:0] clk_sel = 3'h7;
  logic route = 1'b0;
  logic gate2 = 1'b1;
  logic [1:0] prescale = 2'h1;
  io_req_s io_req;
  logic [7:0] rdata;
  logic [7:0] rd_val;
  logic irq0;
  logic irq2;
  logic baud;
  logic out2;
  int fail_count = 0;
  int comparisons = 0;
  int cycles = 0;

  // Gates of channels 0 and 1 stay open; channel 2's gate and the clock selects follow the tests.
  programmable_interval_timer #(.NUM_CH(3), .DIV(2)) i_programmable_interval_timer (
    .sys_clk_i(clk), .rst_i(rst), .io_req_i(io_req), .external_timer_clock_i(ext_clk),
    .channel01_gate_i(2'h3), .channel2_gate_i(gate2), .timer_clock_select_cfg_i(clk_sel),
    .prescale_field_i(prescale), .peripheral_routing_cfg_i(route), .rdata_o(rdata), .irq0_o(irq0),
    .irq2_o(irq2), .baud_clk_o(baud), .channel2_output_o(out2));

  pit_host i_pit_host (.sys_clk_i(clk), .rdata_i(rdata), .io_req_o(io_req));

  // 125 MHz clock.
  initial
  begin
    forever #4 clk = ~clk;
  end

  // Cuts a hung run short.
  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      fail_count++;
      end_sim();
    end
  end

  // Compares one value and counts the outcome.
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("ERROR t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask

  // Reads one port and compares the byte.
  task automatic rd_chk(input logic [1:0] a, input logic [7:0] exp);
    i_pit_host.read_byte(a, rd_val);
    check(rd_val, exp);
  endtask

  // Rising edges on the external clock pin, then time to settle.
  task automatic pulses(input int n);
    repeat (n)
    begin
      @(negedge clk);
      ext_clk = 1'b1;
      repeat (4) @(negedge clk);
      ext_clk = 1'b0;
      repeat (4) @(negedge clk);
    end
    repeat (8) @(negedge clk);
  endtask

  // Prints the counts and the verdict.
  task automatic end_sim();
    $display("Mismatches %0d, comparisons %0d", fail_count, comparisons);
    if (fail_count == 0 && comparisons > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // Main sequence.
  initial
  begin
    repeat (16) @(negedge clk);
    rst = 1'b0;
    i_pit_host.write_byte(OFS_CTRL, 8'hEE);
    for (int c = 0; c < 3; c++)
      rd_chk(c[1:0], 8'h50);
    i_pit_host.write_byte(OFS_CTRL, 8'h30);
    i_pit_host.write_count(OFS_CH0, 16'h0005, RW_BOTH);
    i_pit_host.write_byte(OFS_CTRL, 8'hE2);
    rd_chk(OFS_CH0, 8'h70);
    pulses(3);
    i_pit_host.write_byte(OFS_CTRL, 8'hC2);
    rd_chk(OFS_CH0, 8'h30);
    rd_chk(OFS_CH0, 8'h03);
    rd_chk(OFS_CH0, 8'h00);
    check({7'h0, irq0}, 8'h00);
    pulses(3);
    check({7'h0, irq0}, 8'h01);
    i_pit_host.write_byte(OFS_CTRL, 8'h00);
    rd_chk(OFS_CH0, 8'h00);
    rd_chk(OFS_CH0, 8'h00);
    i_pit_host.write_byte(OFS_CTRL, 8'h51);
    i_pit_host.write_count(OFS_CH1, 16'h0010, RW_LOW);
    i_pit_host.write_byte(OFS_CTRL, 8'hA0);
    i_pit_host.write_count(OFS_CH2, 16'h0200, RW_HIGH);
    pulses(2);
    i_pit_host.write_byte(OFS_CTRL, 8'hC4);
    rd_chk(OFS_CH1, 8'h11);
    rd_chk(OFS_CH1, 8'h09);
    i_pit_host.write_byte(OFS_CTRL, 8'h80);
    rd_chk(OFS_CH2, 8'h01);
    check({7'h0, out2}, 8'h00);
    // A closed gate holds a mode 0 count; opening it lets the count finish.
    i_pit_host.write_byte(OFS_CTRL, 8'h90);
    i_pit_host.write_count(OFS_CH2, 16'h0001, RW_LOW);
    gate2 = 1'b0;
    pulses(2);
    check({7'h0, out2}, 8'h00);
    gate2 = 1'b1;
    pulses(1);
    check({7'h0, out2}, 8'h01);
    // One-shot: nothing until a gate rising edge, then low for the count.
    i_pit_host.write_byte(OFS_CTRL, 8'h92);
    i_pit_host.write_count(OFS_CH2, 16'h0002, RW_LOW);
    gate2 = 1'b0;
    pulses(1);
    check({7'h0, out2}, 8'h01);
    gate2 = 1'b1;
    pulses(1);
    check({7'h0, out2}, 8'h00);
    pulses(2);
    check({7'h0, out2}, 8'h01);
    // Square wave of count 4 toggles every second tick after the load.
    i_pit_host.write_byte(OFS_CTRL, 8'h96);
    i_pit_host.write_count(OFS_CH2, 16'h0004, RW_LOW);
    pulses(3);
    check({7'h0, out2}, 8'h00);
    pulses(2);
    check({7'h0, out2}, 8'h01);
    // Software strobe: one low tick when the count reaches zero.
    i_pit_host.write_byte(OFS_CTRL, 8'h98);
    i_pit_host.write_count(OFS_CH2, 16'h0002, RW_LOW);
    pulses(3);
    check({7'h0, out2}, 8'h00);
    pulses(1);
    check({7'h0, out2}, 8'h01);
    route = 1'b1;
    i_pit_host.write_byte(OFS_CTRL, 8'h50);
    i_pit_host.write_count(OFS_CH1, 16'h0001, RW_LOW);
    pulses(2);
    check({6'h0, baud, irq2}, 8'h03);
    clk_sel = 3'h6;
    i_pit_host.write_byte(OFS_CTRL, 8'h10);
    i_pit_host.write_count(OFS_CH0, 16'h0004, RW_LOW);
    check({7'h0, irq0}, 8'h00);
    repeat (24) @(negedge clk);
    check({7'h0, irq0}, 8'h00);
    repeat (36) @(negedge clk);
    check({7'h0, irq0}, 8'h01);
    i_pit_host.write_byte(OFS_CTRL, 8'h30);
    check({7'h0, irq0}, 8'h00);
    repeat (2) @(negedge clk);
    i_pit_host.write_byte(OFS_CTRL, 8'h34);
    @(negedge clk);
    check({7'h0, irq0}, 8'h01);
    rd_chk(OFS_CTRL, 8'h00);
    end_sim();
  end
endmodule
